// ### spm_port.sv
// Serial peripheral port, master and slave roles
`timescale 1ns/100ps
`default_nettype none
module spm_port (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Processor side
    input wire logic PWR_REDUCE,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic CTRL_WR,
    input wire spm_pkg::spm_ctrl_t CTRL_WDATA,
    output spm_pkg::spm_ctrl_t CTRL_RDATA,
    input wire logic DATA_WR,
    input wire logic [7:0] DATA_WDATA,
    input wire logic DATA_RD,
    output logic [7:0] DATA_RDATA,
    input wire logic STATUS_RD,
    output logic DONE_FLAG,
    output logic COLLISION_FLAG,
    input wire logic IRQ_ACK,
    output logic IRQ,
    // Pin direction and general output values
    input wire spm_pkg::spm_pins_t PIN_DIR,
    input wire spm_pkg::spm_pins_t PIN_PORT,
    // Serial pins
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE,
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE,
    input wire logic SS_I,
    output logic SS_O,
    output logic SS_OE
);
    import spm_pkg::*;

    spm_ctrl_t ctrl_q;
    spm_state_t state_q;
    logic [3:0] pin_s;
    logic sck_s, mosi_s, miso_s, ss_s;
    logic sck_prev_q;
    logic [7:0] sr_q, rx_sr_q, rx_buf_q, rx_next;
    logic [3:0] edge_q;
    logic sck_q;
    logic transfer_done_flag_q, write_collision_flag_q, armed_q;
    logic active, is_master, is_slave, fallback, s_sel;
    logic tick, m_edge, s_edge, ev, sample, setup, done, busy;
    logic in_bit, tx_bit, flag_clr;

    // Pin inputs pass two flops first
    spm_sync #(.W(4)) u_sync (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .din({SCK_I, MOSI_I, MISO_I, SS_I}),
        .dout(pin_s)
    );

    assign sck_s = pin_s[3];
    assign mosi_s = pin_s[2];
    assign miso_s = pin_s[1];
    assign ss_s = pin_s[0];

    // Role decode
    assign active = ctrl_q.enable && !PWR_REDUCE; // R1
    assign is_master = active && ctrl_q.master;
    assign is_slave = active && !ctrl_q.master;
    assign fallback = is_master && !PIN_DIR.ss && !ss_s; // R19
    assign s_sel = is_slave && !ss_s; // R9 R16

    // Master clock generator
    spm_rate_div u_div (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .run(state_q == ST_SHIFT),
        .half(spm_half_period(ctrl_q.rate, ctrl_q.dbl)), // R22
        .tick(tick)
    );

    // Edge events, shared by both roles
    assign m_edge = (state_q == ST_SHIFT) && tick;
    assign s_edge = s_sel && (sck_s != sck_prev_q); // R14
    assign ev = m_edge || s_edge;
    assign sample = ev && (!edge_q[0] ^ ctrl_q.clock_phase); // R24
    assign setup = ev && !(!edge_q[0] ^ ctrl_q.clock_phase); // R24
    assign done = ev && (edge_q == LAST_EDGE); // R3 R11
    assign busy = (state_q == ST_SHIFT) || (edge_q != 4'h0); // R12
    assign in_bit = is_master ? miso_s : mosi_s; // R8
    assign tx_bit = ctrl_q.lsb_first ? sr_q[0] : sr_q[7]; // R23
    assign rx_next = sample ? spm_shift(rx_sr_q, ctrl_q.lsb_first, in_bit) : rx_sr_q;
    assign flag_clr = armed_q && (DATA_WR || DATA_RD); // R25

    // Control register, master bit dropped by fallback
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= CTRL_RST; // R26
        end else begin
            if (CTRL_WR) begin
                ctrl_q <= CTRL_WDATA; // R21
            end
            if (fallback) begin
                ctrl_q.master <= 1'b0; // R19
            end
        end
    end

    // Master sequencer
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (DATA_WR && is_master && !fallback) begin
                        state_q <= ST_SHIFT; // R2 R6
                    end
                end
                ST_SHIFT: begin
                    if (!is_master || done || fallback) begin
                        state_q <= ST_IDLE; // R3
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Edge counter
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            edge_q <= 4'h0;
        end else if (!active || (is_slave && ss_s) || fallback || done) begin
            edge_q <= 4'h0; // R17
        end else if (ev) begin
            edge_q <= edge_q + 4'h1;
        end
    end

    // SCK level follows idle polarity
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sck_q <= 1'b0;
        end else if (state_q != ST_SHIFT) begin
            sck_q <= ctrl_q.clock_polarity; // R24
        end else if (m_edge) begin
            sck_q <= !sck_q;
        end
    end

    // Slave SCK edge history
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
        end
    end

    // Transmit shift register, single buffered
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sr_q <= DATA_RST;
        end else if (DATA_WR && !busy) begin
            sr_q <= DATA_WDATA; // R10 R12
        end else if (setup && edge_q != 4'h0) begin
            sr_q <= spm_shift(sr_q, ctrl_q.lsb_first, 1'b0); // R23
        end
    end

    // Receive shift register and buffer
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_sr_q <= DATA_RST;
        end else if (is_slave && ss_s) begin
            rx_sr_q <= DATA_RST; // R17
        end else begin
            rx_sr_q <= rx_next; // R8
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_buf_q <= DATA_RST;
        end else if (done) begin
            rx_buf_q <= rx_next; // R7 R13
        end
    end

    // Status flags, a set beats a clear
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            transfer_done_flag_q <= 1'b0;
        end else if (done || fallback) begin
            transfer_done_flag_q <= 1'b1; // R3 R11 R20
        end else if (flag_clr || IRQ_ACK) begin
            transfer_done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            write_collision_flag_q <= 1'b0;
        end else if (DATA_WR && busy) begin
            write_collision_flag_q <= 1'b1; // R25
        end else if (flag_clr) begin
            write_collision_flag_q <= 1'b0; // R25
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            armed_q <= 1'b0;
        end else if (STATUS_RD && (transfer_done_flag_q || write_collision_flag_q)) begin
            armed_q <= 1'b1;
        end else if (flag_clr) begin
            armed_q <= 1'b0;
        end
    end

    // Processor outputs
    assign CTRL_RDATA = ctrl_q;
    assign DATA_RDATA = rx_buf_q;
    assign DONE_FLAG = transfer_done_flag_q;
    assign COLLISION_FLAG = write_collision_flag_q;
    assign IRQ = transfer_done_flag_q && ctrl_q.irq_en && GLOBAL_IRQ_EN; // R4 R20

    // Pin direction overrides
    always_comb begin
        SCK_O = PIN_PORT.sck;
        MOSI_O = PIN_PORT.mosi;
        MISO_O = PIN_PORT.miso;
        SS_O = PIN_PORT.ss; // R18
        SCK_OE = PIN_DIR.sck;
        MOSI_OE = PIN_DIR.mosi;
        MISO_OE = PIN_DIR.miso;
        SS_OE = PIN_DIR.ss;
        if (is_master) begin
            SCK_O = sck_q; // R8
            MOSI_O = tx_bit;
            MISO_OE = 1'b0; // R15
        end else if (is_slave) begin
            MISO_O = tx_bit;
            MISO_OE = PIN_DIR.miso && !ss_s; // R16 R9
            SCK_OE = 1'b0; // R15
            MOSI_OE = 1'b0;
            SS_OE = 1'b0;
        end
    end

    // Cycles since the last master SCK edge
    logic [6:0] gap_q;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            gap_q <= 7'h01;
        end else if (state_q != ST_SHIFT || m_edge) begin
            gap_q <= 7'h01;
        end else begin
            gap_q <= gap_q + 7'h01;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    start_shift_a: assert property (DATA_WR && is_master && !busy && !fallback |=> state_q == ST_SHIFT) // R2
        else $error("data write did not start master shift");
    byte_end_a: assert property (m_edge && edge_q == LAST_EDGE |=> DONE_FLAG && state_q == ST_IDLE) // R3
        else $error("master byte end did not stop and flag");
    irq_raise_a: assert property ($rose(DONE_FLAG) && ctrl_q.irq_en && GLOBAL_IRQ_EN |-> IRQ) // R4
        else $error("interrupt not raised on done");
    rx_hold_a: assert property (done |=> DATA_RDATA == $past(rx_next)) // R7
        else $error("receive buffer not loaded");
    miso_idle_a: assert property (is_slave && ss_s |-> !MISO_OE) // R9
        else $error("miso driven while deselected");
    slave_reset_a: assert property (is_slave && ss_s |=> edge_q == 4'h0 && rx_sr_q == 8'h00) // R17
        else $error("slave logic not reset on deselect");
    fallback_role_a: assert property (fallback |=> !ctrl_q.master && DONE_FLAG && state_q == ST_IDLE) // R19
        else $error("fallback to slave failed");
    slave_inputs_a: assert property (is_slave |-> !MOSI_OE && !SCK_OE && !SS_OE) // R15
        else $error("slave drives an input pin");
    master_miso_a: assert property (is_master |-> !MISO_OE) // R15
        else $error("master drives miso");
    collision_a: assert property (DATA_WR && busy |=> COLLISION_FLAG) // R25
        else $error("collision not flagged");
    sck_idle_a: assert property (is_master && state_q == ST_IDLE ##1 is_master && state_q == ST_IDLE |-> // R24
        SCK_O == $past(ctrl_q.clock_polarity))
        else $error("master sck not at idle level");
    half_rate_a: assert property (m_edge |-> gap_q == spm_half_period(ctrl_q.rate, ctrl_q.dbl)) // R22
        else $error("master sck half period wrong");
    first_bit_a: assert property (DATA_WR && is_master && !busy && !fallback && !CTRL_WR |=> // R2 R23
        MOSI_O == (ctrl_q.lsb_first ? $past(DATA_WDATA[0]) : $past(DATA_WDATA[7])))
        else $error("first data bit wrong");
    sck_toggle_a: assert property (is_master && m_edge && !fallback && !CTRL_WR |=> SCK_O != $past(SCK_O)) // R24
        else $error("master sck did not toggle");
    master_count_a: assert property (is_master && m_edge && !fallback && edge_q != LAST_EDGE |=> // R3
        edge_q == $past(edge_q) + 4'h1)
        else $error("master edge count wrong");
    slave_count_a: assert property (s_sel && s_edge && edge_q != LAST_EDGE |=> edge_q == $past(edge_q) + 4'h1) // R14
        else $error("slave edge count wrong");
    power_off_a: assert property (PWR_REDUCE |=> state_q == ST_IDLE && edge_q == 4'h0) // R1
        else $error("port active while powered down");
    slave_miso_a: assert property (s_sel |-> MISO_OE == PIN_DIR.miso && MISO_O == tx_bit) // R16
        else $error("selected slave miso wrong");
    tx_hold_a: assert property (busy && !setup |=> sr_q == $past(sr_q)) // R12
        else $error("transmit byte changed mid shift");
    slave_load_a: assert property (DATA_WR && !busy |=> sr_q == $past(DATA_WDATA)) // R10
        else $error("idle data write not taken");
    rx_keep_a: assert property (!done |=> DATA_RDATA == $past(DATA_RDATA)) // R13
        else $error("receive buffer changed between bytes");
    write_collision_flag_clear_a: assert property (flag_clr && !(DATA_WR && busy) |=> !COLLISION_FLAG) // R25
        else $error("collision flag not cleared");
    flag_clear_a: assert property (flag_clr && !done && !fallback |=> !DONE_FLAG) // R25
        else $error("done flag not cleared");
    slave_done_a: assert property (s_sel && s_edge && edge_q == LAST_EDGE |=> // R11
        DONE_FLAG && DATA_RDATA == $past(rx_next))
        else $error("slave byte end not flagged");
    slave_quiet_a: assert property (is_slave && ss_s && state_q == ST_IDLE && !DONE_FLAG |=> !DONE_FLAG) // R9
        else $error("deselected slave completed a byte");
    slave_noshift_a: assert property (is_slave && state_q == ST_IDLE |=> state_q == ST_IDLE) // R8
        else $error("slave started its own clock");
    role_keep_a: assert property (!ctrl_q.master && !CTRL_WR |=> !ctrl_q.master) // R21
        else $error("master bit set without a write");
    fallback_irq_a: assert property (fallback && ctrl_q.irq_en && !CTRL_WR |=> IRQ == GLOBAL_IRQ_EN) // R20
        else $error("fallback did not request interrupt");
    disabled_oe_a: assert property (!active |-> SCK_OE == PIN_DIR.sck && MOSI_OE == PIN_DIR.mosi // R26
        && MISO_OE == PIN_DIR.miso && SS_OE == PIN_DIR.ss)
        else $error("pin direction overridden while disabled");
    disabled_out_a: assert property (!active |-> SCK_O == PIN_PORT.sck && MOSI_O == PIN_PORT.mosi // R26
        && MISO_O == PIN_PORT.miso && SS_O == PIN_PORT.ss)
        else $error("pin value overridden while disabled");
    master_oe_a: assert property (is_master |-> SCK_OE == PIN_DIR.sck && MOSI_OE == PIN_DIR.mosi) // R15
        else $error("master overrode a user defined pin");
    ss_gpio_a: assert property (is_master |-> SS_OE == PIN_DIR.ss && SS_O == PIN_PORT.ss) // R18
        else $error("master select pin not general purpose");

    master_byte_c: cover property (state_q == ST_SHIFT ##1 (state_q == ST_SHIFT)[*8] ##[1:300] done);
    slave_byte_c: cover property (s_sel && done);
    fallback_c: cover property (fallback);
    collision_c: cover property (DATA_WR && busy);
    partial_c: cover property (is_slave && $rose(ss_s) && edge_q != 4'h0);
endmodule
`default_nettype wire

// ### spm_pkg.sv
// Constants, types and helpers shared by the serial peripheral port
// Summary of operation
// R1: The port stays inactive while its power-reduction input is set.
// R2: Master: a data write starts the clock generator and shifts the byte out.
// R3: Master: after eight bits the clock stops and the done flag sets.
// R4: Done flag with interrupt enable raises the interrupt request.
// R5: Master never drives slave select itself; software handles it.
// R6: Master sends more bytes by writing again, or ends by raising select.
// R7: Each completed byte is held in a receive buffer returned by data reads.
// R8: Data goes out on MOSI, in on MISO; only the master drives SCK.
// R9: Slave with select high stays idle, MISO released, SCK ignored.
// R10: Slave with select high accepts data writes; shifting waits for select low.
// R11: Slave sets the done flag per byte; next byte may load before reading.
// R12: Transmit is single buffered; no new byte until the shift completes.
// R13: Receive is double buffered; an unread byte is overwritten by the next.
// R14: External SCK low and high phases must exceed two system clocks.
// R15: Enabled master forces MISO input; enabled slave forces MOSI, SCK, select input.
// R16: Slave: select is input; while low MISO drives if configured as output.
// R17: Slave: select rising resets shift logic and bit counter at once.
// R18: Master with select as output: pin is plain output, no effect.
// R19: Master with select as input: low level clears master bit, becomes slave.
// R20: That fallback also sets the done flag and may request an interrupt.
// R21: After fallback the port stays slave until software sets master again.
// R22: Master SCK is clock over 4, 16, 64 or 128, halved by double speed.
// R23: Bit order select one sends least significant bit first, else most.
// R24: Polarity sets idle SCK level; phase picks leading or trailing sample edge.
// R25: Data write during a transfer sets collision; status read then data access clears.
// R26: After reset the port is disabled, slave, flags clear, no overrides.
package spm_pkg;

    localparam int DATA_W = 8;
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [7:0] SCK_DIV_0 = 8'h04;
    localparam logic [7:0] SCK_DIV_1 = 8'h10;
    localparam logic [7:0] SCK_DIV_2 = 8'h40;
    localparam logic [7:0] SCK_DIV_3 = 8'h80;

    typedef struct packed {
        logic irq_en;
        logic enable;
        logic lsb_first;
        logic master;
        logic clock_polarity;
        logic clock_phase;
        logic [1:0] rate;
        logic dbl;
    } spm_ctrl_t;

    typedef struct packed {
        logic mosi;
        logic miso;
        logic sck;
        logic ss;
    } spm_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } spm_state_t;

    localparam spm_ctrl_t CTRL_RST = 9'h000;
    localparam logic [7:0] DATA_RST = 8'h00;

    // System clocks per SCK half period
    function automatic logic [6:0] spm_half_period(input logic [1:0] rate, input logic dbl);
        logic [7:0] d;
        d = SCK_DIV_0;
        case (rate)
            2'h0: d = SCK_DIV_0;
            2'h1: d = SCK_DIV_1;
            2'h2: d = SCK_DIV_2;
            default: d = SCK_DIV_3;
        endcase
        d = dbl ? (d >> 2) : (d >> 1);
        return d[6:0];
    endfunction

    // One bit of shift in either order
    function automatic logic [7:0] spm_shift(input logic [7:0] v, input logic lsb, input logic b);
        return lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction

endpackage

// ### spm_sync.sv
// Two-flop synchroniser for the port pins
`timescale 1ns/100ps
`default_nettype none
module spm_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### spm_rate_div.sv
// SCK half-period enable generator
`timescale 1ns/100ps
`default_nettype none
module spm_rate_div (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [6:0] half,
    output logic tick
);
    logic [6:0] cnt_q;

    assign tick = run && (cnt_q == half - 7'h01);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 7'h00;
        end else if (!run || tick) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_q + 7'h01;
        end
    end
endmodule
`default_nettype wire

// ### spm_peer.sv
// Far-side serial slave device used while the port is master
`timescale 1ns/100ps
`default_nettype none
module spm_peer (
    // Serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    // Frame settings
    input wire logic clock_polarity,
    input wire logic clock_phase,
    input wire logic lsb,
    input wire logic [7:0] tx,
    output logic [7:0] rx
);
    int k;
    function automatic logic pick(input int i);
        return (i > 7) ? ~miso : (lsb ? tx[i] : tx[7-i]);
    endfunction
    initial begin
        miso = 1'b0;
        rx = 8'h00;
        k = 0;
    end
    always @(negedge ss_n) begin
        k = 0;
        if (!clock_phase) miso = pick(0);
    end
    // Released line shows no stale value
    always @(posedge ss_n) miso = ~miso;
    always @(sck) begin
        if (!ss_n) begin
            if ((sck != clock_polarity) ^ clock_phase) begin
                rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            end else begin
                if (!clock_phase) k++;
                miso = pick(k);
                if (clock_phase) k++;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import spm_pkg::*;
    logic clk, rstn, pwr, gie, ctrl_wr, data_wr, data_rd, stat_rd, irq_ack, done, coll, irq;
    spm_ctrl_t cw, cr, c;
    logic [7:0] dw, dr, b, t, m, g, peer_tx, peer_rx;
    spm_pins_t dir, port;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
    logic ext_sck, ext_mosi, ext_ss, peer_on, peer_miso, sck_last;
    int errors, n_tests, seed, tog, gap, ivl, cyc, it;
    wire sck_w = sck_oe ? sck_o : ext_sck;
    wire mosi_w = mosi_oe ? mosi_o : ext_mosi;
    wire miso_w = miso_oe ? miso_o : peer_miso;
    wire ss_w = ss_oe ? ss_o : ext_ss;
    wire peer_ss = ss_w | ~peer_on;
    spm_port dut (.SYS_CLK(clk), .RSTN(rstn), .PWR_REDUCE(pwr), .GLOBAL_IRQ_EN(gie),
        .CTRL_WR(ctrl_wr), .CTRL_WDATA(cw), .CTRL_RDATA(cr), .DATA_WR(data_wr), .DATA_WDATA(dw),
        .DATA_RD(data_rd), .DATA_RDATA(dr), .STATUS_RD(stat_rd), .DONE_FLAG(done),
        .COLLISION_FLAG(coll), .IRQ_ACK(irq_ack), .IRQ(irq), .PIN_DIR(dir), .PIN_PORT(port),
        .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
        .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_I(ss_w),
        .SS_O(ss_o), .SS_OE(ss_oe));
    spm_peer peer (.sck(sck_w), .mosi(mosi_w), .ss_n(peer_ss), .miso(peer_miso), .clock_polarity(c.clock_polarity),
        .clock_phase(c.clock_phase), .lsb(c.lsb_first), .tx(peer_tx), .rx(peer_rx));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // SCK toggle count and spacing
    always @(posedge clk) begin
        cyc++;
        if (sck_o !== sck_last) begin
            tog++;
            ivl = gap;
            gap = 1;
        end else gap++;
        sck_last = sck_o;
        if (cyc == 40000) begin
            errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            conclude();
        end
    end
    task automatic conclude;
        $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wrctl(input spm_ctrl_t v);
        @(negedge clk);
        ctrl_wr = 1'b1;
        cw = v;
        @(negedge clk);
        ctrl_wr = 1'b0;
    endtask
    task automatic wrdat(input logic [7:0] v);
        @(negedge clk);
        data_wr = 1'b1;
        dw = v;
        @(negedge clk);
        data_wr = 1'b0;
    endtask
    task automatic ack;
        @(negedge clk);
        irq_ack = 1'b1;
        @(negedge clk);
        irq_ack = 1'b0;
    endtask
    // External master: six-cycle phases
    task automatic sxfer(input logic [7:0] v, input int nb, output logic [7:0] got);
        got = 8'h00;
        for (int i = 0; i < nb; i++) begin
            if (c.clock_phase) ext_sck = ~c.clock_polarity;
            ext_mosi = c.lsb_first ? v[i] : v[7-i];
            cyc_n(6);
            ext_sck = ~ext_sck;
            got = c.lsb_first ? {miso_w, got[7:1]} : {got[6:0], miso_w};
            cyc_n(6);
            if (!c.clock_phase) ext_sck = c.clock_polarity;
        end
    endtask
    function automatic int half(input logic [1:0] r, input logic d);
        return (r == 2'h0 ? 4 : r == 2'h1 ? 16 : r == 2'h2 ? 64 : 128) >> (d ? 2 : 1);
    endfunction
    initial begin
        {pwr, gie, ctrl_wr, data_wr, data_rd, stat_rd, irq_ack, ext_sck, ext_mosi, peer_on} = '0;
        {cw, c, dw, peer_tx, errors, n_tests, tog, gap, ivl, cyc} = '0;
        seed = 95;
        ext_ss = 1'b1;
        rstn = 1'b0;
        dir = spm_pins_t'($random(seed));
        port = spm_pins_t'($random(seed));
        cyc_n(6);
        chk(cr, 9'h000, "ctrl rst");
        chk({done, coll, irq}, 9'h000, "flags rst");
        chk({mosi_oe, miso_oe, sck_oe, ss_oe}, dir, "oe rst");
        chk({mosi_o, miso_o, sck_o, ss_o}, port, "o rst");
        rstn = 1'b1;
        $display("test reset done");
        dir = 4'b1011;
        port = 4'b0001;
        peer_on = 1'b1;
        pwr = 1'b1;
        c = 9'h1a2;
        wrctl(c);
        tog = 0;
        wrdat(8'h5a);
        cyc_n(200);
        chk(done, 1'b0, "pwr done");
        chk(tog[8:0], 9'h000, "pwr sck");
        pwr = 1'b0;
        $display("test power done");
        for (it = 0; it < 8; it++) begin
            c = spm_ctrl_t'($random(seed));
            {c.irq_en, c.enable, c.master} = 3'b111;
            if (c.rate == 2'h0) c.rate = 2'h1;
            gie = $random(seed);
            dir.miso = $random(seed);
            b = $random(seed);
            peer_tx = $random(seed);
            port.ss = 1'b1;
            wrctl(c);
            cyc_n(3);
            chk(sck_o, c.clock_polarity, "idle sck");
            port.ss = 1'b0;
            cyc_n(4);
            chk({ss_oe, ss_o}, 9'h002, "ss gpio");
            tog = 0;
            wrdat(b);
            cyc_n(5);
            wrdat(~b);
            cyc_n(1);
            chk(coll, 1'b1, "coll set");
            chk(miso_oe, 1'b0, "miso oe");
            for (int i = 0; i < 6000 && done !== 1'b1; i++) cyc_n(1);
            cyc_n(1);
            chk(done, 1'b1, "done");
            chk(irq, gie, "irq");
            chk(peer_rx, b, "mosi byte");
            chk(dr, peer_tx, "rx buf");
            chk(tog[8:0], 9'h010, "sck edges");
            chk(ivl[8:0], half(c.rate, c.dbl), "half period");
            chk(sck_o, c.clock_polarity, "end sck");
            @(negedge clk) stat_rd = 1'b1;
            @(negedge clk) stat_rd = 1'b0;
            data_rd = 1'b1;
            @(negedge clk) data_rd = 1'b0;
            chk({done, coll}, 9'h000, "flag clr");
        end
        port.ss = 1'b1;
        $display("test master done");
        gie = 1'b1;
        dir.ss = 1'b0;
        wrctl(c);
        ext_ss = 1'b0;
        cyc_n(5);
        chk(cr.master, 1'b0, "fallback");
        chk({done, irq}, 9'h003, "fallback irq");
        chk({sck_oe, mosi_oe}, 9'h000, "fallback oe");
        ack();
        chk(done, 1'b0, "ack");
        chk(cr.master, 1'b0, "stays slave");
        ext_ss = 1'b1;
        peer_on = 1'b0;
        cyc_n(3);
        wrctl(c);
        chk(cr.master, 1'b1, "master again");
        $display("test fallback done");
        for (it = 0; it < 3; it++) begin
            c = spm_ctrl_t'($random(seed));
            {c.irq_en, c.enable, c.master} = 3'b110;
            dir = 4'b0100;
            ext_sck = c.clock_polarity;
            wrctl(c);
            t = $random(seed);
            m = $random(seed);
            wrdat(t);
            cyc_n(3);
            chk(miso_oe, 1'b0, "miso idle");
            repeat (4) begin
                ext_sck = ~ext_sck;
                cyc_n(6);
            end
            chk(done, 1'b0, "sck ignored");
            ext_ss = 1'b0;
            cyc_n(4);
            chk(miso_oe, 1'b1, "miso drive");
            chk({sck_oe, mosi_oe, ss_oe}, 9'h000, "slave oe");
            sxfer(m, 8, g);
            cyc_n(6);
            chk(done, 1'b1, "slave done");
            chk(dr, m, "slave rx");
            chk(g, t, "slave tx");
            ack();
            sxfer(~m, 3, g);
            ext_ss = 1'b1;
            cyc_n(4);
            chk(done, 1'b0, "partial");
            ext_ss = 1'b0;
            cyc_n(4);
            t = $random(seed);
            sxfer(t, 8, g);
            cyc_n(6);
            chk(dr, t, "resync rx");
            ext_ss = 1'b1;
            ack();
        end
        $display("test slave done");
        conclude();
    end
endmodule
`default_nettype wire
